// >>> bsc_pkg.sv
// shared constants and types for boot selection and code security
package bsc_pkg;

  // ************************************************************
  // boot modes
  // ************************************************************
  typedef enum logic [2:0] {
    BSC_BOOT_PARALLEL = 3'h0,
    BSC_BOOT_SERIAL   = 3'h1,
    BSC_BOOT_WAIT     = 3'h2,
    BSC_BOOT_FLASH    = 3'h3,
    BSC_BOOT_SPI      = 3'h4,
    BSC_BOOT_I2C      = 3'h5,
    BSC_BOOT_OTP      = 3'h6
  } bsc_boot_type;

  // ************************************************************
  // stored word encodings and fixed figures
  // ************************************************************
  localparam logic [15:0] BSC_WORD_KEY     = 16'h55AA;
  localparam int          BSC_PWD_WAIT    = 16;
  localparam logic [4:0]  BSC_PWD_WAIT_CNT = 5'(BSC_PWD_WAIT);
  localparam logic [4:0]  BSC_CNT_RST     = 5'h00;
  localparam int          BSC_PWD_BITS    = 128;
  localparam int          BSC_HALF_BITS   = 64;

  typedef struct packed {
    logic [15:0] key_word;
    logic [15:0] mode_word;
  } bsc_cfg_type;

  typedef struct packed {
    logic        secure_access;
    logic        secure_read;
    logic        external_exec;
    logic        jtag_inspect;
  } bsc_access_type;

endpackage : bsc_pkg

// >>> bsc_top.sv
// boot mode selection and code security unit
// ************************************************************
// boot mode selection and code security unit
// ************************************************************
// Functional notes
// - straps decode four boot modes when test reset low
// - with emulator attached, ignore both straps, use vector ram words
// - invalid vector ram boot word falls back to wait
// - emulation boot can reach every strap selectable mode
// - configured boot goes to flash unless otp words redirect
// - any invalid otp word means boot from flash
// - otp loaders limited to serial, spi, i2c, otp
// - wait option loops on a breakpoint, no latch trip
// - no hardware hold in reset mode exists
// - 128-bit password read with fixed 16 wait states
// - secure memory closed until full 128-bit key matches
// - while locked block jtag inspect, external exec, exports
// - emulator secure access trips latch unless debug unlocked
// - lower 64 key bits matching grants debug unlock only
// - lower password half all ones grants debug unlock freely
module bsc_top (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // pins
  input  wire logic                  boot_strap_high,
  input  wire logic                  boot_strap_low,
  input  wire logic                  test_rst,
  // stored configuration words
  input  wire bsc_pkg::bsc_cfg_type  emu_cfg,
  input  wire bsc_pkg::bsc_cfg_type  otp_cfg,
  // password fetch from flash and key from software
  input  wire logic                  pwd_start,
  input  wire logic [127:0]          pwd_data,
  input  wire logic [127:0]          key_value,
  // attempted accesses
  input  wire bsc_pkg::bsc_access_type access,
  // outputs
  output logic [2:0]                 boot_mode,
  output logic                       boot_valid,
  output logic                       full_unlock,
  output logic                       debug_unlock,
  output logic                       debug_security_latch,
  output logic                       emu_connect,
  output logic                       access_block,
  output logic                       pwd_busy
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] sh_reg, sl_reg, tr_reg;
  logic [2:0] sh_next, sl_next, tr_next;
  // marks the chains as filled with real pin samples after reset
  logic [2:0] fill_reg, fill_next;
  logic       pins_stable;

  always_comb begin
    sh_next = {sh_reg[1:0], boot_strap_high};
    sl_next = {sl_reg[1:0], boot_strap_low};
    tr_next = {tr_reg[1:0], test_rst};
    fill_next = {fill_reg[1:0], 1'b1};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 3'h0;
      sl_reg <= 3'h0;
      tr_reg <= 3'h0;
      fill_reg <= 3'h0;
    end else begin
      sh_reg <= sh_next;
      sl_reg <= sl_next;
      tr_reg <= tr_next;
      fill_reg <= fill_next;
    end
  end

  // reset zeros in the chains must not be taken for strap levels
  assign pins_stable = fill_reg[2] && (sh_reg[1] == sh_reg[2]) && (sl_reg[1] == sl_reg[2])
                       && (tr_reg[1] == tr_reg[2]);

  // ************************************************************
  // boot selection
  // ************************************************************
  function automatic logic [2:0] bsc_decode(input logic [15:0] key, input logic [15:0] md,
                                           input logic [2:0] fallback, input logic emu);
    logic [2:0] res;
    res = fallback;
    if (key == bsc_pkg::BSC_WORD_KEY) begin
      unique case (md[2:0])
        3'h1: res = bsc_pkg::BSC_BOOT_SERIAL;
        3'h4: res = bsc_pkg::BSC_BOOT_SPI;
        3'h5: res = bsc_pkg::BSC_BOOT_I2C;
        3'h6: res = bsc_pkg::BSC_BOOT_OTP;
        3'h3: res = bsc_pkg::BSC_BOOT_FLASH;
        3'h0: res = emu ? bsc_pkg::BSC_BOOT_PARALLEL : fallback;
        3'h2: res = emu ? bsc_pkg::BSC_BOOT_WAIT : fallback;
        default: res = fallback;
      endcase
    end
    return res;
  endfunction : bsc_decode

  logic [2:0] mode_reg, mode_next;
  logic       valid_reg, valid_next;

  always_comb begin
    mode_next  = mode_reg;
    valid_next = valid_reg;
    if (!valid_reg && pins_stable) begin
      valid_next = 1'b1;
      if (tr_reg[2]) begin
        // emulator attached, both straps ignored
        mode_next = bsc_decode(emu_cfg.key_word, emu_cfg.mode_word,
                               bsc_pkg::BSC_BOOT_WAIT, 1'b1);
      end else if (sh_reg[2] && sl_reg[2]) begin
        mode_next = bsc_decode(otp_cfg.key_word, otp_cfg.mode_word,
                               bsc_pkg::BSC_BOOT_FLASH, 1'b0);
      end else begin
        mode_next = {1'b0, sh_reg[2], sl_reg[2]}; // wait is a software loop
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg  <= bsc_pkg::BSC_BOOT_WAIT;
      valid_reg <= 1'b0;
    end else begin
      mode_reg  <= mode_next;
      valid_reg <= valid_next;
    end
  end

  assign boot_mode  = mode_reg;
  assign boot_valid = valid_reg;

  // ************************************************************
  // password compare
  // ************************************************************
  logic [4:0] cnt_reg, cnt_next;
  logic       busy_reg, busy_next;
  logic       full_reg, full_next;
  logic       dbg_reg, dbg_next;
  logic       latch_reg, latch_next;
  logic       blk_reg, blk_next;
  logic       emu_reg, emu_next;

  always_comb begin
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    full_next  = full_reg;
    dbg_next   = dbg_reg;
    latch_next = latch_reg;
    if (pwd_start && !busy_reg) begin
      busy_next = 1'b1;
      cnt_next  = bsc_pkg::BSC_PWD_WAIT_CNT;
    end else if (busy_reg) begin
      if (cnt_reg == 5'h01) begin
        busy_next = 1'b0;
        full_next = (key_value == pwd_data);
        dbg_next  = (key_value[63:0] == pwd_data[63:0])
                    || (&pwd_data[63:0]);
      end
      cnt_next = cnt_reg - 5'h01;
    end
    if (tr_reg[2] && access.secure_access && !dbg_reg) begin
      latch_next = 1'b1;
    end
    blk_next = !full_reg && (access.jtag_inspect || access.external_exec
               || access.secure_read);
    // connection drops in the same cycle as the latch trips
    emu_next = tr_reg[2] && !latch_next;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= bsc_pkg::BSC_CNT_RST;
      busy_reg  <= 1'b0;
      full_reg  <= 1'b0;
      dbg_reg   <= 1'b0;
      latch_reg <= 1'b0;
      blk_reg   <= 1'b0;
      emu_reg   <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      busy_reg  <= busy_next;
      full_reg  <= full_next;
      dbg_reg   <= dbg_next;
      latch_reg <= latch_next;
      blk_reg   <= blk_next;
      emu_reg   <= emu_next;
    end
  end

  assign full_unlock          = full_reg;
  assign debug_unlock         = dbg_reg;
  assign debug_security_latch = latch_reg;
  assign emu_connect          = emu_reg;
  assign access_block         = blk_reg;
  assign pwd_busy             = busy_reg;

  // ************************************************************
  // checks
  // ************************************************************
  reset_locked_a: assert property (@(posedge sys_clk) $fell(rst) |-> !full_reg && !dbg_reg)
    else $error("unlock set after reset");
  // busy stands sixteen cycles, then drops
  compare_time_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(busy_reg) |-> busy_reg [*8] ##1 busy_reg [*8] ##1 !busy_reg)
    else $error("password read time wrong");
  full_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(full_reg) |-> $past(key_value) == $past(pwd_data))
    else $error("unlock without key match");
  latch_trip_a: assert property (@(posedge sys_clk) disable iff (rst)
    tr_reg[2] && access.secure_access && !dbg_reg |=> latch_reg ##1 !emu_connect)
    else $error("latch did not trip");
  block_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
    !full_reg && access.jtag_inspect |=> blk_reg)
    else $error("locked access not blocked");
  blank_debug_a: assert property (@(posedge sys_clk) disable iff (rst)
    busy_reg && cnt_reg == 5'h01 && (&pwd_data[63:0]) |=> dbg_reg)
    else $error("blank password not debug unlocked");
  emu_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    !valid_reg && pins_stable && tr_reg[2] && emu_cfg.key_word != bsc_pkg::BSC_WORD_KEY
    |=> boot_mode == bsc_pkg::BSC_BOOT_WAIT)
    else $error("bad emulation words not wait");
  otp_flash_a: assert property (@(posedge sys_clk) disable iff (rst)
    !valid_reg && pins_stable && !tr_reg[2] && sh_reg[2] && sl_reg[2]
    && otp_cfg.key_word != bsc_pkg::BSC_WORD_KEY |=> boot_mode == bsc_pkg::BSC_BOOT_FLASH)
    else $error("bad otp words not flash");

endmodule : bsc_top

// >>> bsc_flash_model.sv
// flash password store seen by the code security unit
module bsc_flash_model (
  // programmed password
  pwd_value,
  // to the device
  pwd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  input  wire logic [127:0] pwd_value;
  output logic      [127:0] pwd_data;
  // whole 128 bits offered on each fetch, never all zeros
  assign pwd_data = pwd_value;
endmodule : bsc_flash_model

// >>> bsc_top_tb_top.sv
// testbench for boot selection and code security
module bsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // programmed, never all zeros; reserved words kept zero by software
  localparam logic [127:0] PWD = 128'h0123456789ABCDEFFEDCBA9876543210;
  localparam logic [15:0]  KEY = bsc_pkg::BSC_WORD_KEY;
  logic                    sys_clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    sh = 1'b0;
  logic                    sl = 1'b0;
  logic                    tr = 1'b0;
  logic                    pwd_start = 1'b0;
  bsc_pkg::bsc_cfg_type    emu_cfg = '0;
  bsc_pkg::bsc_cfg_type    otp_cfg = '0;
  bsc_pkg::bsc_access_type acc = '0;
  logic [127:0]            pwd_value = PWD;
  logic [127:0]            key_value = '0;
  logic [127:0]            pwd_data;
  logic [2:0]              boot_mode;
  logic                    boot_valid, full_unlock, debug_unlock, latch;
  logic                    emu_connect, access_block, pwd_busy;
  int                      n_errors = 0;
  int                      n_checks = 0;

  always #50 sys_clk = ~sys_clk;

  bsc_top u_bsc_top (.sys_clk(sys_clk), .rst(rst), .boot_strap_high(sh),
    .boot_strap_low(sl), .test_rst(tr), .emu_cfg(emu_cfg), .otp_cfg(otp_cfg),
    .pwd_start(pwd_start), .pwd_data(pwd_data), .key_value(key_value),
    .access(acc), .boot_mode(boot_mode), .boot_valid(boot_valid),
    .full_unlock(full_unlock), .debug_unlock(debug_unlock),
    .debug_security_latch(latch), .emu_connect(emu_connect),
    .access_block(access_block), .pwd_busy(pwd_busy));
  bsc_flash_model u_bsc_flash_model (.pwd_value(pwd_value), .pwd_data(pwd_data));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask : tick

  task automatic do_reset();
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
  endtask : do_reset

  task automatic boot(input logic h, l, t, input logic [15:0] ek, em, ok, om,
                      input logic [2:0] e);
    sh = h;
    sl = l;
    tr = t;
    emu_cfg = {ek, em};
    otp_cfg = {ok, om};
    do_reset();
    for (int i = 0; i < 20 && boot_valid !== 1'b1; i++) tick(1);
    chk("boot_valid", 8'h01, 8'(boot_valid));
    chk("boot_mode", 8'(e), 8'(boot_mode));
  endtask : boot

  task automatic pw(input logic [127:0] p, k, input logic ef, ed);
    int n;
    n = 0;
    pwd_value = p;
    key_value = k;
    pwd_start = 1'b1;
    tick(1);
    pwd_start = 1'b0;
    for (int i = 0; i < 3 && pwd_busy !== 1'b1; i++) tick(1);
    while (pwd_busy === 1'b1 && n < 40) begin
      n++;
      tick(1);
    end
    chk("busy_cycles", 8'h10, 8'(n));
    chk("full_unlock", 8'(ef), 8'(full_unlock));
    chk("debug_unlock", 8'(ed), 8'(debug_unlock));
  endtask : pw

  task automatic t_reset();
    do_reset();
    chk("reset_mode", 8'h02, 8'(boot_mode));
    chk("reset_unlock", 8'h00, 8'({full_unlock, debug_unlock, latch}));
  endtask : t_reset

  task automatic t_boot();
    logic [2:0] sx[4] = '{3'h0, 3'h1, 3'h2, 3'h3};
    logic [2:0] ol[4] = '{3'h1, 3'h4, 3'h5, 3'h6};
    for (int i = 0; i < 4; i++) boot(i[1], i[0], 1'b0, 0, 0, 0, 0, sx[i]);
    for (int i = 0; i < 4; i++) boot(1, 1, 0, 0, 0, KEY, 16'(ol[i]), ol[i]);
    boot(1, 1, 0, 0, 0, KEY, 16'h0002, 3'h3);
    for (int m = 0; m < 7; m++) boot(1, 1, 1, KEY, 16'(m), 0, 0, 3'(m));
    boot(0, 0, 1, 16'h0000, 16'h0000, 0, 0, 3'h2);
    boot(0, 0, 1, KEY, 16'h0007, 0, 0, 3'h2);
  endtask : t_boot

  task automatic t_pwd();
    boot(1, 1, 0, 0, 0, 0, 0, 3'h3);
    pw(PWD, PWD, 1'b1, 1'b1);
    acc.jtag_inspect = 1'b1;
    tick(2);
    chk("access_block", 8'h00, 8'(access_block));
    pw(PWD, {~PWD[127:64], PWD[63:0]}, 1'b0, 1'b1);
    tick(1);
    chk("access_block", 8'h01, 8'(access_block));
    pw(PWD, ~PWD, 1'b0, 1'b0);
    pw({PWD[127:64], 64'hFFFFFFFFFFFFFFFF}, '0, 1'b0, 1'b1);
    acc = '0;
  endtask : t_pwd

  task automatic t_latch();
    boot(1, 0, 1, KEY, 16'h0002, 0, 0, 3'h2);
    chk("emu_connect", 8'h01, 8'(emu_connect));
    pw(PWD, {~PWD[127:64], PWD[63:0]}, 1'b0, 1'b1);
    acc.secure_access = 1'b1;
    tick(3);
    chk("latch", 8'h00, 8'(latch));
    pw(PWD, ~PWD, 1'b0, 1'b0);
    tick(3);
    chk("latch", 8'h01, 8'(latch));
    chk("emu_connect", 8'h00, 8'(emu_connect));
    acc = '0;
    tick(3);
    chk("latch", 8'h01, 8'(latch));
    do_reset();
    chk("latch", 8'h00, 8'(latch));
  endtask : t_latch

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  initial begin
    #1000000;
    n_errors++;
    results();
  end

  initial begin
    t_reset();
    t_boot();
    t_pwd();
    t_latch();
    results();
  end
endmodule : bsc_top_tb_top
